// ===== rtl/tef_energy_filter.sv
// Decimating trapezoidal energy filter: raw samples in, one sum per decimated sample out once the 2L+G window has filled.
`timescale 1ns/1ps
module tef_energy_filter
    import tef_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Raw sample stream
    input wire logic [SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid_in,
    output logic sample_ready_out,
    // Configuration
    input wire logic [CFG_W-1:0] length_in,
    input wire logic [CFG_W-1:0] gap_in,
    input wire logic [1:0] dec_order_in,
    output logic config_error_out,
    // Energy result stream
    output logic signed [ACC_W-1:0] energy_out,
    output logic energy_valid_out,
    input wire logic energy_ready_in
);
    typedef struct packed {
        logic [CFG_W-1:0] len;
        logic [CFG_W-1:0] gap;
        logic [1:0] ord;
        logic cfg_err;
        logic [DEC_W-1:0] dec_acc;
        logic [CNT_W-1:0] dec_cnt;
        logic signed [ACC_W-1:0] acc;
        logic [CNT_W-1:0] seen;
        logic signed [ACC_W-1:0] out_data;
        logic out_valid;
    } tef_state_t;

    tef_state_t st_r;
    tef_state_t st_nxt;

    tef_stream_if #(.W(SAMPLE_W)) in_push_if ();
    tef_stream_if #(.W(SAMPLE_W)) in_pop_if ();
    tef_stream_if #(.W(DEC_W)) a_push_if ();
    tef_stream_if #(.W(DEC_W)) a_pop_if ();
    tef_stream_if #(.W(DIFF_W)) b_push_if ();
    tef_stream_if #(.W(DIFF_W)) b_pop_if ();

    logic [$clog2(IN_DEPTH):0] in_level;
    logic [$clog2(DLY_DEPTH):0] a_level;
    logic [$clog2(DLY_DEPTH):0] b_level;

    logic cfg_changed;
    logic cfg_bad;
    logic flush;
    logic stall;
    logic raw_take;
    logic dec_done;
    logic [CNT_W-1:0] dec_last;
    logic [CNT_W-1:0] lg_sum;
    logic [CNT_W-1:0] base_width;
    logic [DEC_W-1:0] dec_sum;
    logic a_at_depth;
    logic b_at_depth;
    logic [DEC_W-1:0] x_old;
    logic signed [DIFF_W-1:0] u_new;
    logic signed [DIFF_W-1:0] v_old;
    logic signed [ACC_W-1:0] acc_nxt;
    logic [CNT_W-1:0] seen_inc;

    // Raw input buffer; its ready is the back-pressure seen by the sample source.
    assign in_push_if.valid = sample_valid_in;
    assign in_push_if.data = sample_in;
    assign sample_ready_out = in_push_if.ready;

    tef_fifo #(.W(SAMPLE_W), .DEPTH(IN_DEPTH)) u_in_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(1'b0),
        .level_out(in_level),
        .push_if(in_push_if),
        .pop_if(in_pop_if)
    );

    // The recursion is split as (x[k] - x[k-L]) - (u[k-L-G]), where u is the L-sample
    // difference; this needs only the two delay memories and no third tap.
    tef_fifo #(.W(DEC_W), .DEPTH(DLY_DEPTH)) u_len_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(flush),
        .level_out(a_level),
        .push_if(a_push_if),
        .pop_if(a_pop_if)
    );

    tef_fifo #(.W(DIFF_W), .DEPTH(DLY_DEPTH)) u_lg_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(flush),
        .level_out(b_level),
        .push_if(b_push_if),
        .pop_if(b_pop_if)
    );

    assign lg_sum = {1'b0, length_in} + {1'b0, gap_in};
    assign cfg_bad = (length_in == '0) || (lg_sum >= LG_LIMIT);
    assign cfg_changed = (length_in != st_r.len) || (gap_in != st_r.gap)
        || (dec_order_in != st_r.ord);
    assign flush = cfg_changed || cfg_bad;
    assign stall = st_r.out_valid && !energy_ready_in;
    assign raw_take = in_pop_if.valid && !stall && !flush;
    assign in_pop_if.ready = !stall && !flush;

    // Group size D = 2^N with N the shift that the order code selects in DEC_SHIFT.
    assign dec_last = CNT_W'((7'h01 << DEC_SHIFT[st_r.ord]) - 7'h01);
    assign dec_sum = st_r.dec_acc + {{(DEC_W - SAMPLE_W){1'b0}}, in_pop_if.data};
    assign dec_done = raw_take && (st_r.dec_cnt == dec_last);

    // Before a delay memory holds its full depth the missing history counts as zero.
    assign a_at_depth = a_level == {1'b0, st_r.len};
    assign b_at_depth = b_level == ({1'b0, st_r.len} + {1'b0, st_r.gap});
    assign x_old = a_at_depth ? a_pop_if.data : '0;
    assign u_new = $signed({1'b0, dec_sum}) - $signed({1'b0, x_old});
    assign v_old = b_at_depth ? $signed(b_pop_if.data) : '0;

    assign a_push_if.valid = dec_done;
    assign a_push_if.data = dec_sum;
    assign a_pop_if.ready = dec_done && a_at_depth;
    assign b_push_if.valid = dec_done;
    assign b_push_if.data = u_new;
    assign b_pop_if.ready = dec_done && b_at_depth;

    // Unit weights, no division: the sum grows to L times the step.
    assign acc_nxt = st_r.acc + ACC_W'(u_new) - ACC_W'(v_old);
    assign base_width = {st_r.len, 1'b0} + {1'b0, st_r.gap};
    assign seen_inc = (st_r.seen == '1) ? st_r.seen : st_r.seen + CNT_W'(1);

    always_comb begin
        st_nxt = st_r;
        st_nxt.len = length_in;
        st_nxt.gap = gap_in;
        st_nxt.ord = dec_order_in;
        st_nxt.cfg_err = cfg_bad;
        if (flush) begin
            st_nxt.dec_acc = '0;
            st_nxt.dec_cnt = '0;
            st_nxt.acc = '0;
            st_nxt.seen = '0;
            st_nxt.out_valid = 1'b0;
        end else if (!stall) begin
            if (st_r.out_valid) begin
                st_nxt.out_valid = 1'b0;
            end
            if (raw_take) begin
                if (dec_done) begin
                    st_nxt.dec_acc = '0;
                    st_nxt.dec_cnt = '0;
                    st_nxt.acc = acc_nxt;
                    st_nxt.seen = seen_inc;
                    st_nxt.out_data = acc_nxt;
                    st_nxt.out_valid = seen_inc >= base_width;
                end else begin
                    st_nxt.dec_acc = dec_sum;
                    st_nxt.dec_cnt = st_r.dec_cnt + CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign energy_out = st_r.out_data;
    assign energy_valid_out = st_r.out_valid;
    assign config_error_out = st_r.cfg_err;

    // Helper copies of the previous cycle's terms for the checks below.
    logic signed [ACC_W-1:0] prev_acc_r;
    logic signed [ACC_W-1:0] prev_delta_r;
    logic prev_step_r;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            prev_acc_r <= '0;
            prev_delta_r <= '0;
            prev_step_r <= 1'b0;
        end else begin
            prev_acc_r <= st_r.acc;
            prev_delta_r <= ACC_W'(u_new) - ACC_W'(v_old);
            prev_step_r <= dec_done && !flush;
        end
    end

    recursion_step_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        prev_step_r |-> st_r.acc == prev_acc_r + prev_delta_r)
    else $error("Accumulator did not follow the recursion.");

    one_result_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (dec_done && !flush && seen_inc >= base_width) |=> energy_valid_out)
    else $error("Decimated sample produced no result.");

    no_early_valid_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        energy_valid_out |-> st_r.seen >= base_width && base_width != '0)
    else $error("Result valid before delay memories filled.");

    len_depth_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !st_r.cfg_err |-> a_level <= {1'b0, st_r.len} && b_level <= base_width)
    else $error("Delay memory deeper than its window.");

    bad_config_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        cfg_bad |=> st_r.seen == '0 && !energy_valid_out && config_error_out)
    else $error("Length plus gap limit not enforced.");

    clear_change_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        cfg_changed |=> st_r.acc == '0 && a_level == '0 && b_level == '0)
    else $error("Filter state not cleared on configuration change.");

    dec_group_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (raw_take && !dec_done) |=> st_r.dec_cnt == $past(st_r.dec_cnt) + CNT_W'(1)
            && st_r.dec_acc == $past(dec_sum))
    else $error("Raw sample not folded into the decimated sum.");

    no_drop_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (in_pop_if.valid && in_pop_if.ready) |-> raw_take)
    else $error("Raw sample left the buffer without being summed.");

    rate_ok_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (in_level < 5'(IN_DEPTH)) |-> sample_ready_out)
    else $error("Input refused while buffer has room.");

    hold_stall_a: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (energy_valid_out && !energy_ready_in && !flush) |=>
            energy_valid_out && $stable(energy_out))
    else $error("Result dropped while downstream stalled.");
endmodule

// ===== rtl/tef_pkg.sv
// Shared widths, depths, limits and timing figures of the trapezoid energy filter.
package tef_pkg;
    // Raw sample, decimated sum, window difference and accumulator widths.
    localparam int SAMPLE_W = 14;
    localparam int DEC_W = 20;
    localparam int DIFF_W = 21;
    localparam int ACC_W = 27;
    localparam int CFG_W = 5;
    localparam int CNT_W = 6;
    // Buffer depths.
    localparam int IN_DEPTH = 16;
    localparam int DLY_DEPTH = 32;
    // Length plus gap must stay below this bound.
    localparam logic [CNT_W-1:0] LG_LIMIT = 6'h20;
    // Decimation order codes 0..3 select shifts of 0, 2, 4 and 6.
    localparam logic [3:0][2:0] DEC_SHIFT = {3'h6, 3'h4, 3'h2, 3'h0};
    // Raw sample period and the clock period, both in ns.
    localparam int SAMPLE_PERIOD_NS = 50;
    localparam int CLK_PERIOD_NS = 4;
    // Shortest spacing between raw samples in clock cycles, rounded down.
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    // Averaging interval of one decimated sample at order code 0, in ns.
    localparam int AVG_BASE_NS = 50;
endpackage

// ===== rtl/tef_stream_if.sv
// Valid/ready word stream between the filter and its buffers.
`timescale 1ns/1ps
interface tef_stream_if #(
    parameter int W = 14
) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/tef_fifo.sv
// Parameterised register-array FIFO with flush and fill level.
`timescale 1ns/1ps
module tef_fifo
    import tef_pkg::*;
#(
    parameter int W = 14,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic flush_in,
    output logic [AW:0] level_out,
    // Streams
    tef_stream_if.snk push_if,
    tef_stream_if.src pop_if
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] level;
    } tef_fifo_state_t;

    tef_fifo_state_t st_r;
    tef_fifo_state_t st_nxt;
    logic push;
    logic pop;

    assign push_if.ready = st_r.level < (AW + 1)'(DEPTH);
    assign pop_if.valid = st_r.level != '0;
    // Head word comes straight from the register array so a pop and a push
    // may share a cycle, which the delay lines rely on.
    assign pop_if.data = st_r.mem[st_r.rd];
    assign level_out = st_r.level;
    assign push = push_if.valid && push_if.ready;
    assign pop = pop_if.valid && pop_if.ready;

    always_comb begin
        st_nxt = st_r;
        if (flush_in) begin
            st_nxt.wr = '0;
            st_nxt.rd = '0;
            st_nxt.level = '0;
        end else begin
            if (push) begin
                st_nxt.mem[st_r.wr] = push_if.data;
                st_nxt.wr = st_r.wr + AW'(1);
            end
            if (pop) begin
                st_nxt.rd = st_r.rd + AW'(1);
            end
            if (push && !pop) begin
                st_nxt.level = st_r.level + (AW + 1)'(1);
            end else if (pop && !push) begin
                st_nxt.level = st_r.level - (AW + 1)'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ===== sim/tef_adc_model.sv
// Behavioural converter that offers a counted burst of raw samples on valid/ready.
`timescale 1ns/1ps
module tef_adc_model
    import tef_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Burst control and data source
    input wire logic start_in,
    input wire logic [15:0] count_in,
    input wire logic [7:0] spacing_in,
    input wire logic [SAMPLE_W-1:0] word_in,
    // Sample stream
    output logic [SAMPLE_W-1:0] sample_out,
    output logic valid_out,
    input wire logic ready_in
);
    logic [15:0] remain_r;
    logic [7:0] wait_r;
    // An offered sample is held until an edge samples ready high.
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            valid_out <= 1'b0;
            sample_out <= '0;
            remain_r <= 16'h0000;
            wait_r <= 8'h00;
        end else if (start_in) begin
            remain_r <= count_in;
            wait_r <= 8'h00;
        end else if (!valid_out || ready_in) begin
            if (remain_r != 16'h0000 && wait_r + 8'h01 >= spacing_in) begin
                valid_out <= 1'b1;
                sample_out <= word_in;
                remain_r <= remain_r - 16'h0001;
                wait_r <= 8'h00;
            end else begin
                // A released data line toggles so a stale word never passes as fresh.
                valid_out <= 1'b0;
                sample_out <= ~sample_out;
                wait_r <= wait_r + 8'h01;
            end
        end
    end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench of the trapezoid energy filter against a queue-based reference.
`timescale 1ns/1ps
`define TEF_CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED at %0t got %h expected %h", $time, (a), (b)); end end
module tb_top
    import tef_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [SAMPLE_W-1:0] sample_in;
    logic sample_valid_in;
    logic sample_ready_out;
    logic [CFG_W-1:0] length_in = 5'h01;
    logic [CFG_W-1:0] gap_in = 5'h01;
    logic [1:0] dec_order_in = 2'h0;
    logic config_error_out;
    logic signed [ACC_W-1:0] energy_out;
    logic energy_valid_out;
    logic energy_ready_in = 1'b1;
    logic start = 1'b0;
    logic [15:0] count = 16'h0000;
    logic [7:0] spacing = 8'h01;
    logic [SAMPLE_W-1:0] word = '0;
    logic [31:0] seed = 32'h09B25443;
    int error_cnt = 0;
    int samples_checked = 0;
    int raw_q[$];
    longint xs[$];
    longint grp;
    longint acc;
    int gcnt, res_n, cur_l, cur_g, cur_d, step_at, k;
    bit step_mode = 1'b0;
    bit bad_mode = 1'b0;

    tef_energy_filter dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .sample_in(sample_in), .sample_valid_in(sample_valid_in),
        .sample_ready_out(sample_ready_out), .length_in(length_in), .gap_in(gap_in),
        .dec_order_in(dec_order_in), .config_error_out(config_error_out),
        .energy_out(energy_out), .energy_valid_out(energy_valid_out),
        .energy_ready_in(energy_ready_in));

    tef_adc_model adc_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start),
        .count_in(count), .spacing_in(spacing), .word_in(word), .sample_out(sample_in),
        .valid_out(sample_valid_in), .ready_in(sample_ready_out));

    function automatic logic [31:0] lfsr_f(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    initial begin
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // Random or step data and random back-pressure keep the input FIFO filling and draining.
    always @(posedge sys_clk_in) begin
        seed <= lfsr_f(seed);
        energy_ready_in <= seed[20] | seed[5];
        if (step_mode) begin
            word <= (raw_q.size() >= step_at) ? 14'h3FFF : 14'h0000;
        end else begin
            word <= seed[SAMPLE_W-1:0];
        end
    end

    // Reference model: group raw samples, then apply the windowed difference.
    always @(posedge sys_clk_in) begin
        if (rst_n_in && sample_valid_in && sample_ready_out) begin
            raw_q.push_back(int'(sample_in));
            grp += longint'(sample_in);
            gcnt++;
            if (gcnt == cur_d) begin
                xs.push_back(grp);
                grp = 0;
                gcnt = 0;
            end
        end
        if (rst_n_in && bad_mode && energy_valid_out) begin
            `TEF_CHK(energy_valid_out, 1'b0)
        end
        if (rst_n_in && energy_valid_out && energy_ready_in) begin
            k = res_n + 2 * cur_l + cur_g - 1;
            if (k < xs.size()) begin
                acc = 0;
                for (int i = 0; i < cur_l; i++) begin
                    acc += xs[k - i] - xs[k - cur_l - cur_g - i];
                end
                `TEF_CHK(energy_out, acc[ACC_W-1:0])
            end
            res_n++;
        end
    end

    task automatic set_cfg(input int l, input int g, input int ord);
        @(posedge sys_clk_in);
        length_in <= l[CFG_W-1:0];
        gap_in <= g[CFG_W-1:0];
        dec_order_in <= ord[1:0];
        repeat (4) @(posedge sys_clk_in);
    endtask

    task automatic run_case(input int l, input int g, input int ord, input int sp,
            input int n, input bit stp);
        int d;
        int w;
        d = 1 << (2 * ord);
        bad_mode = 1'b0;
        set_cfg(l, g, ord);
        `TEF_CHK(config_error_out, 1'b0)
        raw_q.delete();
        xs.delete();
        grp = 0;
        gcnt = 0;
        res_n = 0;
        cur_l = l;
        cur_g = g;
        cur_d = d;
        step_at = n * d / 2;
        step_mode = stp;
        count <= 16'(n * d);
        spacing <= 8'(sp);
        start <= 1'b1;
        @(posedge sys_clk_in);
        start <= 1'b0;
        w = 0;
        while (res_n < n - 2 * l - g + 1 && w < 20000) begin
            @(posedge sys_clk_in);
            w++;
        end
        repeat (40) @(posedge sys_clk_in);
        `TEF_CHK(raw_q.size(), n * d)
        `TEF_CHK(res_n, n - 2 * l - g + 1)
        $display("test done L=%0d G=%0d D=%0d results=%0d", l, g, d, res_n);
    endtask

    task automatic bad_case(input int l, input int g);
        bad_mode = 1'b1;
        set_cfg(l, g, 0);
        `TEF_CHK(config_error_out, 1'b1)
        $display("test done refused L=%0d G=%0d", l, g);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        // Run cases keep L+G below 32 with gaps of one to fifteen and cover the four orders; two refused settings come between the fourth and fifth run case.
        run_case(1, 1, 0, 1, 40, 1'b0);
        run_case(4, 3, 1, SAMPLE_CYCLES, 20, 1'b0);
        run_case(3, 3, 2, 1, 12, 1'b0);
        run_case(2, 3, 3, 1, 8, 1'b0);
        bad_case(0, 3);
        bad_case(20, 12);
        run_case(16, 15, 0, 2, 70, 1'b0);
        run_case(28, 3, 3, 1, 64, 1'b1);
        close_out();
    end

    // The whole run needs about 6200 cycles, the longest case about 4100; the limit leaves wide margin.
    initial begin
        repeat (60000) @(posedge sys_clk_in);
        error_cnt++;
        close_out();
    end
endmodule
